// File: core/hcss_pkg.sv
// constants for the host chip-select controller
package hcss_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] HCSS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HCSS_ADDR_OFS   = 8'h04;
  localparam logic [7:0] HCSS_WDATA_OFS  = 8'h08;
  localparam logic [7:0] HCSS_GO_OFS     = 8'h0C;
  localparam logic [7:0] HCSS_RDATA_OFS  = 8'h10;
  localparam logic [7:0] HCSS_STAT_OFS   = 8'h14;
  localparam logic [7:0] HCSS_BASE_OFS   = 8'h18;
  localparam logic [7:0] HCSS_LCNT_OFS   = 8'h1C;
  localparam logic [7:0] HCSS_REV_OFS    = 8'h20;
  localparam logic [7:0] HCSS_OPT_OFS    = 8'h24;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_VALID_BIT = 0;
  localparam int CTRL_READ_BIT  = 1;
  localparam int CTRL_LOOP_BIT  = 2;
  localparam int CTRL_POL_BIT   = 3;
  localparam int CTRL_LANE_LSB  = 4;
  localparam int CTRL_WIDTH     = 6;
  localparam logic [5:0] CTRL_RESET = 6'h30;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_MISS_BIT = 2;

  // ****************************************
  // select window and device map
  // ****************************************
  localparam logic [31:0] BASE_RESET   = 32'h0040_0000;
  localparam int          MATCH_BITS   = 10;
  localparam logic [31:0] REV_OFFSET   = 32'h0000_0000;
  localparam int          DEV_ADDR_W   = 18;
  localparam int          MEMSEL_BIT   = 18;
  localparam int          DATA_W       = 16;
  localparam int          REV_W        = 8;
  localparam int          LCNT_W       = 16;

  // ****************************************
  // fixed option fields of the select machine
  // ****************************************
  localparam logic [1:0] PORT_WIDTH_16     = 2'h2;
  localparam logic [1:0] SELECT_DELAY_HALF = 2'h3;
  localparam logic       NO_BURST_ON       = 1'b1;
  localparam logic       EXT_ACK_ON        = 1'b1;
  localparam logic [3:0] WAIT_COUNT_ZERO   = 4'h0;
  localparam logic       NEG_NORMAL        = 1'b0;
  localparam logic       RELAX_OFF         = 1'b0;
  localparam logic       HOLD_OFF          = 1'b0;
  localparam logic       PARITY_OFF        = 1'b0;
  localparam logic       PROTECT_OFF       = 1'b0;
  localparam logic [1:0] MACHINE_GENERAL   = 2'h0;
  localparam logic [2:0] ACC_TYPE_NONE     = 3'h0;
  localparam logic [2:0] ACC_TYPE_MASK_OFF = 3'h0;

  typedef enum logic [2:0] {
    HCSS_IDLE,
    HCSS_ADDR,
    HCSS_SEL,
    HCSS_END
  } hcss_state_t;
endpackage

// File: core/hcss_decode.sv
// window decode of a host address against the select base
module hcss_decode (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  input  wire logic        valid,
  output logic             hit
);
  import hcss_pkg::*;

  // ****************************************
  // compare upper bits only, no access-type check
  // ****************************************
  always_comb begin
    hit = valid && (addr[31 -: MATCH_BITS] == base[31 -: MATCH_BITS]);
  end
endmodule

// File: core/hcss_top.sv
// host chip-select controller: apb registers in, companion bus pins out
module hcss_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               bus_clk,
  output logic                               sel_n,
  output logic      [hcss_pkg::DEV_ADDR_W-1:0] dev_addr,
  output logic                               mem_sel,
  output logic                               rd_n,
  output logic      [1:0]                    we_n,
  output logic      [hcss_pkg::DATA_W-1:0]   data_o,
  output logic                               data_oe_n,
  input  wire logic [hcss_pkg::DATA_W-1:0]   data_i,
  input  wire logic                          wait_i
);
  import hcss_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [31:0]           addr_r;
  logic [DATA_W-1:0]     wdata_r;
  logic [DATA_W-1:0]     rdata_r;
  logic [31:0]           base_r;
  logic                  done_r;
  logic                  miss_r;
  logic [LCNT_W-1:0]     lcnt_r;
  logic [REV_W-1:0]      rev_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic [31:0]           prdata_r;
  logic                  phase_r;
  logic                  wait_s1_r;
  logic                  wait_s2_r;
  logic [DATA_W-1:0]     din_s1_r;
  logic [DATA_W-1:0]     din_s2_r;
  hcss_state_t           state_r;
  logic                  cur_read_r;
  logic                  cur_loop_r;
  logic                  sel_n_r;
  logic [DEV_ADDR_W-1:0] dev_addr_r;
  logic                  mem_sel_r;
  logic                  rd_n_r;
  logic [1:0]            we_n_r;
  logic [DATA_W-1:0]     data_o_r;
  logic                  data_oe_n_r;
  logic                  apb_wr;
  logic                  apb_setup;
  logic                  go_wr;
  logic                  loop_start;
  logic                  start;
  logic [31:0]           start_addr;
  logic                  hit;
  logic                  bclk_rise;
  logic                  ack;
  logic                  mapped;
  logic [31:0]           rd_mux;
  logic [31:0]           opt_word;

  // ****************************************
  // apb slave
  // ****************************************
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready_r && pwrite && !pslverr_r;
  assign go_wr     = apb_wr && (paddr[7:0] == HCSS_GO_OFS);

  always_comb begin
    opt_word = {9'h000, ACC_TYPE_MASK_OFF, ACC_TYPE_NONE, MACHINE_GENERAL, PROTECT_OFF,
                PARITY_OFF, HOLD_OFF, RELAX_OFF, NEG_NORMAL, WAIT_COUNT_ZERO, EXT_ACK_ON,
                NO_BURST_ON, SELECT_DELAY_HALF, PORT_WIDTH_16};
  end

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr[7:0])
      HCSS_CTRL_OFS:  rd_mux = {26'h0000000, ctrl_r};
      HCSS_ADDR_OFS:  rd_mux = addr_r;
      HCSS_WDATA_OFS: rd_mux = {16'h0000, wdata_r};
      HCSS_GO_OFS:    rd_mux = 32'h0000_0000;
      HCSS_RDATA_OFS: rd_mux = {16'h0000, rdata_r};
      HCSS_STAT_OFS:  rd_mux = {29'h00000000, miss_r, done_r, (state_r != HCSS_IDLE)};
      HCSS_BASE_OFS:  rd_mux = base_r;
      HCSS_LCNT_OFS:  rd_mux = {16'h0000, lcnt_r};
      HCSS_REV_OFS:   rd_mux = {24'h000000, rev_r};
      HCSS_OPT_OFS:   rd_mux = opt_word;
      default:        mapped = 1'b0;
    endcase
    if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  // answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup && !mapped;
      prdata_r  <= (apb_setup && mapped && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RESET;
      addr_r  <= 32'h0000_0000;
      wdata_r <= 16'h0000;
      base_r  <= BASE_RESET;
    end else if (apb_wr) begin
      case (paddr[7:0])
        HCSS_CTRL_OFS:  ctrl_r  <= pwdata[CTRL_WIDTH-1:0];
        HCSS_ADDR_OFS:  addr_r  <= pwdata;
        HCSS_WDATA_OFS: wdata_r <= pwdata[DATA_W-1:0];
        HCSS_BASE_OFS:  base_r  <= pwdata;
        default:        ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // ****************************************
  // bus clock and pin synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= !phase_r;
    end
  end

  // bus clock rises at the edge that ends this cycle
  assign bclk_rise = !phase_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
      din_s1_r  <= 16'h0000;
      din_s2_r  <= 16'h0000;
    end else begin
      wait_s1_r <= wait_i;
      wait_s2_r <= wait_s1_r;
      din_s1_r  <= data_i;
      din_s2_r  <= din_s1_r;
    end
  end

  // polarity set by software to match the device strap
  assign ack = ctrl_r[CTRL_POL_BIT] ? wait_s2_r : !wait_s2_r;

  // ****************************************
  // general-purpose select machine
  // ****************************************
  assign loop_start = ctrl_r[CTRL_LOOP_BIT] && !go_wr;
  assign start_addr = go_wr ? addr_r : (base_r + REV_OFFSET);
  assign start      = (state_r == HCSS_IDLE) && bclk_rise && (go_wr || loop_start);

  hcss_decode u_decode (
    .addr  (start_addr),
    .base  (base_r),
    .valid (ctrl_r[CTRL_VALID_BIT]),
    .hit   (hit)
  );

  // one beat per start, never more; reads never served locally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= HCSS_IDLE;
      cur_read_r <= 1'b0;
      cur_loop_r <= 1'b0;
    end else begin
      case (state_r)
        HCSS_IDLE: begin
          if (start && hit) begin
            state_r    <= HCSS_ADDR;
            cur_read_r <= go_wr ? ctrl_r[CTRL_READ_BIT] : 1'b1;
            cur_loop_r <= !go_wr;
          end
        end
        HCSS_ADDR: begin
          state_r <= HCSS_SEL;
        end
        HCSS_SEL: begin
          if (bclk_rise && ack) begin
            state_r <= HCSS_END;
          end
        end
        HCSS_END: begin
          state_r <= HCSS_IDLE;
        end
        default: begin
          state_r <= HCSS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // device pins
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_addr_r  <= '0;
      mem_sel_r   <= 1'b0;
      data_o_r    <= 16'h0000;
    end else if (start && hit) begin
      dev_addr_r <= start_addr[DEV_ADDR_W-1:0];
      mem_sel_r  <= start_addr[MEMSEL_BIT];
      data_o_r   <= wdata_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_n_r     <= 1'b1;
      rd_n_r      <= 1'b1;
      we_n_r      <= 2'h3;
      data_oe_n_r <= 1'b1;
    end else begin
      case (state_r)
        HCSS_ADDR: begin
          sel_n_r     <= 1'b0;
          rd_n_r      <= !cur_read_r;
          we_n_r      <= cur_read_r ? 2'h3 : ~ctrl_r[CTRL_LANE_LSB +: 2];
          data_oe_n_r <= cur_read_r;
        end
        HCSS_SEL: begin
          if (bclk_rise && ack) begin
            sel_n_r     <= 1'b1;
            rd_n_r      <= 1'b1;
            we_n_r      <= 2'h3;
            data_oe_n_r <= 1'b1;
          end
        end
        default: begin
          sel_n_r     <= 1'b1;
          rd_n_r      <= 1'b1;
          we_n_r      <= 2'h3;
          data_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // results and status
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 16'h0000;
      rev_r   <= 8'h00;
      lcnt_r  <= 16'h0000;
    end else if (state_r == HCSS_SEL && bclk_rise && ack && cur_read_r) begin
      rdata_r <= din_s2_r;
      if (cur_loop_r) begin
        rev_r  <= din_s2_r[REV_W-1:0];
        lcnt_r <= lcnt_r + 16'h0001;
      end
    end
  end

  // sticky flags: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      miss_r <= 1'b0;
    end else begin
      if (state_r == HCSS_END && !cur_loop_r) begin
        done_r <= 1'b1;
      end else if (apb_wr && paddr[7:0] == HCSS_STAT_OFS && pwdata[STAT_DONE_BIT]) begin
        done_r <= 1'b0;
      end
      if (start && !hit && go_wr) begin
        miss_r <= 1'b1;
      end else if (apb_wr && paddr[7:0] == HCSS_STAT_OFS && pwdata[STAT_MISS_BIT]) begin
        miss_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign bus_clk   = phase_r;
  assign sel_n     = sel_n_r;
  assign dev_addr  = dev_addr_r;
  assign mem_sel   = mem_sel_r;
  assign rd_n      = rd_n_r;
  assign we_n      = we_n_r;
  assign data_o    = data_o_r;
  assign data_oe_n = data_oe_n_r;
endmodule

// File: sim/hcss_checker.sv
// port-level assertions for the host chip-select controller
module hcss_checker (
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [31:0]                     paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic                            pready,
  input wire logic                            bus_clk,
  input wire logic                            sel_n,
  input wire logic [hcss_pkg::DEV_ADDR_W-1:0] dev_addr,
  input wire logic                            mem_sel,
  input wire logic                            rd_n,
  input wire logic [1:0]                      we_n,
  input wire logic [hcss_pkg::DATA_W-1:0]     data_o,
  input wire logic                            data_oe_n,
  input wire logic                            wait_i
);
  import hcss_pkg::*;
  logic pol_r;
  logic ack;
  // ****************************************
  // shadow of the ack polarity bit
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == {24'h0, HCSS_CTRL_OFS}) begin
      pol_r <= pwdata[CTRL_POL_BIT];
    end
  end
  assign ack = pol_r ~^ wait_i;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_answer: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_read_strobe: assert property (!rd_n |-> !sel_n && data_oe_n && we_n == 2'h3)
    else $error("read strobe without select or with drive");
  a_write_strobe: assert property (we_n != 2'h3 |-> !sel_n && !data_oe_n && rd_n)
    else $error("write strobe without select or drive");
  a_sel_half_clock: assert property ($fell(sel_n) |-> !bus_clk)
    else $error("select not half a bus clock after address");
  a_hold_while_sel: assert property (!sel_n |-> $stable(dev_addr) &&
    $stable(mem_sel) && $stable(data_o))
    else $error("address or data moved while selected");
  a_end_needs_ack: assert property ($rose(sel_n) |-> $past(ack, 2))
    else $error("cycle ended without acknowledge");
  a_end_on_edge: assert property ($rose(sel_n) |-> bus_clk && rd_n && we_n == 2'h3)
    else $error("cycle end not on bus clock edge");
  a_single_beat: assert property ($rose(sel_n) |=> sel_n [*2])
    else $error("select reasserted too soon");
endmodule

bind hcss_top hcss_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .bus_clk(bus_clk), .sel_n(sel_n), .dev_addr(dev_addr), .mem_sel(mem_sel), .rd_n(rd_n),
  .we_n(we_n), .data_o(data_o), .data_oe_n(data_oe_n), .wait_i(wait_i));

// File: sim/hcss_dev_model.sv
// behavioural companion device: revision register, small buffer, ack
module hcss_dev_model #(
  parameter logic [7:0] REV_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic        bus_clk,
  input  wire logic        sel_n,
  input  wire logic [17:0] dev_addr,
  input  wire logic        mem_sel,
  input  wire logic        rd_n,
  input  wire logic [1:0]  we_n,
  input  wire logic [15:0] data_o,
  input  wire logic        ack_high,
  input  wire logic [3:0]  ack_dly,
  output logic      [15:0] data_i,
  output logic             wait_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:15];
  logic [15:0] rdval;
  logic [3:0]  cnt;
  logic        ack;
  initial begin
    cnt = 4'h0;
    ack = 1'b0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // low select picks registers, high picks the buffer
  assign rdval = mem_sel ? mem[dev_addr[4:1]] :
                 (dev_addr == 18'h0 ? {REV_CODE, REV_CODE} : 16'h0);
  // bus not driven outside a read: inverse pattern
  assign data_i = (!sel_n && !rd_n) ? rdval : ~rdval;
  // ack dropped as soon as select leaves
  assign wait_i = ack_high ~^ (ack && !sel_n);
  always @(posedge bus_clk) begin
    if (sel_n) begin
      cnt <= 4'h0;
      ack <= 1'b0;
    end else if (!ack && (!rd_n || we_n != 2'h3)) begin
      if (cnt == ack_dly) begin
        ack <= 1'b1;
        if (mem_sel && !we_n[1]) mem[dev_addr[4:1]][15:8] <= data_o[15:8];
        if (mem_sel && !we_n[0]) mem[dev_addr[4:1]][7:0] <= data_o[7:0];
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the host chip-select controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hcss_pkg::*;
  localparam logic [7:0] REV = 8'hC3;  // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_clk, sel_n;
  logic        mem_sel, rd_n, data_oe_n, wait_i, ack_high, e;
  logic [31:0] paddr, pwdata, prdata, v, st, c;
  logic [17:0] dev_addr;
  logic [1:0]  we_n;
  logic [15:0] data_o, data_i;
  logic [3:0]  ack_dly;
  int          err_count, n_tests, sel_lo, s0;
  hcss_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_clk(bus_clk), .sel_n(sel_n), .dev_addr(dev_addr),
    .mem_sel(mem_sel), .rd_n(rd_n), .we_n(we_n), .data_o(data_o), .data_oe_n(data_oe_n),
    .data_i(data_i), .wait_i(wait_i));
  hcss_dev_model #(.REV_CODE(REV)) u_dev (.bus_clk(bus_clk), .sel_n(sel_n),
    .dev_addr(dev_addr), .mem_sel(mem_sel), .rd_n(rd_n), .we_n(we_n), .data_o(data_o),
    .ack_high(ack_high), .ack_dly(ack_dly), .data_i(data_i), .wait_i(wait_i));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(negedge pclk) if (sel_n === 1'b0) sel_lo++;
  // ****************************************
  // shared tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      give_verdict;
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start lands on a low bus clock phase, then poll for done or miss
  task go_op(input logic [31:0] ctl, input logic [31:0] ad, input logic [31:0] wd);
    int n;
    apb(1'b1, HCSS_CTRL_OFS, ctl);
    apb(1'b1, HCSS_ADDR_OFS, ad);
    apb(1'b1, HCSS_WDATA_OFS, wd);
    @(negedge pclk);
    if (bus_clk) @(negedge pclk);
    apb(1'b1, HCSS_GO_OFS, 32'h0);
    for (n = 0; n < 200; n++) begin
      apb(1'b0, HCSS_STAT_OFS, 32'h0);
      if (v[2:1] != 2'h0) break;
    end
    if (n == 200) begin
      err_count++;
      give_verdict;
    end
    st = v;
    apb(1'b1, HCSS_STAT_OFS, 32'h6);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ack_high = 1'b0;
    ack_dly = 4'h0;
    err_count = 0;
    n_tests = 0;
    sel_lo = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, HCSS_CTRL_OFS, 32'h0);
    check(v, 32'h0000_0030);
    apb(1'b0, HCSS_BASE_OFS, 32'h0);
    check(v, 32'h0040_0000);
    apb(1'b0, HCSS_OPT_OFS, 32'h0);
    check(v, 32'h0000_003E);
    apb(1'b0, 8'h28, 32'h0);
    check({v[31:1], e}, 32'h0000_0001);
    s0 = sel_lo;
    go_op(32'h0000_0032, 32'h0040_0000, 32'h0);
    check(st, 32'h0000_0004);
    check(sel_lo, s0);
    for (int p = 0; p < 2; p++) begin
      ack_high <= p[0];
      ack_dly <= 4'(3 * p);
      c = 32'h0000_0031 | (32'(p) << 3);
      go_op(c, 32'h0044_0002, 32'h0000_A55A + 32'(p));
      check(st, 32'h0000_0002);
      go_op(c | 32'h2, 32'h007C_0002, 32'h0);
      apb(1'b0, HCSS_RDATA_OFS, 32'h0);
      check(v, 32'h0000_A55A + 32'(p));
      go_op(c | 32'h2, 32'h0040_0000, 32'h0);
      apb(1'b0, HCSS_RDATA_OFS, 32'h0);
      check(v, {16'h0, REV, REV});
    end
    // low byte lane only: high byte keeps the earlier word
    go_op(32'h0000_0019, 32'h0044_0002, 32'h0000_1234);
    go_op(32'h0000_001B, 32'h0044_0002, 32'h0);
    apb(1'b0, HCSS_RDATA_OFS, 32'h0);
    check(v, 32'h0000_A534);
    s0 = sel_lo;
    go_op(c, 32'h0080_0000, 32'h0);
    check(st, 32'h0000_0004);
    check(sel_lo, s0);
    apb(1'b1, HCSS_BASE_OFS, 32'h0080_0000);
    go_op(c | 32'h2, 32'h0080_0000, 32'h0);
    apb(1'b0, HCSS_RDATA_OFS, 32'h0);
    check(v, {16'h0, REV, REV});
    apb(1'b1, HCSS_BASE_OFS, 32'h0040_0000);
    apb(1'b1, HCSS_CTRL_OFS, c | 32'h4);
    repeat (200) @(posedge pclk);
    apb(1'b1, HCSS_CTRL_OFS, c);
    repeat (40) @(posedge pclk);
    apb(1'b0, HCSS_LCNT_OFS, 32'h0);
    check({31'h0, v != 32'h0}, 32'h1);
    apb(1'b0, HCSS_REV_OFS, 32'h0);
    check(v, {24'h0, REV});
    give_verdict;
  end
endmodule
